// [logic/powerdown_mask_registers.sv]
//
// Purpose : Output buffer power-down, global standby mask and sync/reference registers
// Assumes : Host drives serial pins synchronous to i_sys_clk, slow enough to sample
// Notes   : Frame is read flag, 7-bit address, 8-bit data
`timescale 1ns/1ps

module powerdown_mask_registers
  import powerdown_mask_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_sen_n,
  input  wire logic       i_sclk,
  input  wire logic       i_sdio,
  input  wire logic       i_global_standby,
  input  wire logic       i_shared_sync_standby_pin,
  output logic            o_sdout,
  output logic            o_sdout_oe_n,
  output logic            o_frame_clock_driver_off,
  output logic            o_bit_clock_driver_off,
  output logic            o_chan_a_lane1_driver_off,
  output logic            o_chan_a_lane0_driver_off,
  output logic            o_chan_b_lane1_driver_off,
  output logic            o_chan_b_lane0_driver_off,
  output logic            o_standby_active,
  output logic            o_sample_clock_buffer_off,
  output logic            o_reference_amplifier_off,
  output logic            o_bandgap_off,
  output logic            o_long_wakeup,
  output logic            o_sync_pulse,
  output logic            o_reference_control_source,
  output logic [1:0]      o_reference_select,
  output logic            o_single_ended_clock_enable
);

  // ****************************************************************
  // Serial port
  // ****************************************************************
  spi_phase_t  phase_q;
  logic [3:0]  cnt_q;
  logic [14:0] shift_q;
  logic        rd_q;
  logic [6:0]  addr_q;
  logic [7:0]  rd_shift_q;
  logic        sclk_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        wr_pulse;
  logic [7:0]  wr_data;
  logic [7:0]  rd_mux;

  logic [7:0]  obuf_q;
  logic [7:0]  gmask_q;
  logic [7:0]  syncref_q;

  assign sclk_rise = i_sclk & ~sclk_q;
  assign sclk_fall = ~i_sclk & sclk_q;
  assign wr_data   = {shift_q[6:0], i_sdio};
  assign wr_pulse  = (phase_q == PH_DATA) && sclk_rise && (cnt_q == CNT_FRAME_LAST) && !rd_q;

  always_comb
  begin
    unique case ({shift_q[5:0], i_sdio})
      OFS_OUTPUT_BUFFER_POWERDOWN:     rd_mux = obuf_q;
      OFS_GLOBAL_POWERDOWN_MASK:       rd_mux = gmask_q;
      OFS_SYNC_REFERENCE_CLOCK_SELECT: rd_mux = syncref_q;
      default:                         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= i_sclk;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      phase_q    <= PH_IDLE;
      cnt_q      <= 4'h0;
      shift_q    <= 15'h0000;
      rd_q       <= 1'b0;
      addr_q     <= 7'h00;
      rd_shift_q <= 8'h00;
    end
    else if (i_sen_n)
    begin
      phase_q <= PH_IDLE;
      cnt_q   <= 4'h0;
    end
    else
    begin
      unique case (phase_q)
        PH_IDLE:
        begin
          phase_q <= PH_HEADER;
        end
        PH_HEADER:
        begin
          if (sclk_rise)
          begin
            shift_q <= {shift_q[13:0], i_sdio};
            cnt_q   <= cnt_q + 4'h1;
            if (cnt_q == CNT_HEADER_LAST)
            begin
              phase_q    <= PH_DATA;
              rd_q       <= shift_q[6];
              addr_q     <= {shift_q[5:0], i_sdio};
              rd_shift_q <= rd_mux;
            end
          end
        end
        PH_DATA:
        begin
          if (sclk_rise)
          begin
            shift_q <= {shift_q[13:0], i_sdio};
            cnt_q   <= cnt_q + 4'h1;
            if (cnt_q == CNT_FRAME_LAST)
            begin
              phase_q <= PH_DONE;
            end
          end
          if (sclk_fall)
          begin
            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
          end
        end
        PH_DONE:
        begin
          phase_q <= PH_DONE;
        end
      endcase
    end
  end

  // Read data drives out on falling edges during the data phase
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_sdout      <= 1'b0;
      o_sdout_oe_n <= 1'b1;
    end
    else
    begin
      o_sdout_oe_n <= !((phase_q == PH_DATA) && rd_q && !i_sen_n);
      if (phase_q == PH_DATA && sclk_fall)
      begin
        o_sdout <= rd_shift_q[7];
      end
    end
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  // reset to zero
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      obuf_q <= RST_REGISTER;
    end
    else if (wr_pulse && addr_q == OFS_OUTPUT_BUFFER_POWERDOWN)
    begin
      obuf_q <= wr_data & MASK_OUTPUT_BUFFER;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      gmask_q <= RST_REGISTER;
    end
    else if (wr_pulse && addr_q == OFS_GLOBAL_POWERDOWN_MASK)
    begin
      gmask_q <= wr_data & MASK_GLOBAL_MASK;
    end
  end

  // field layout, bit 4 reads zero
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      syncref_q <= RST_REGISTER;
    end
    else if (wr_pulse && addr_q == OFS_SYNC_REFERENCE_CLOCK_SELECT)
    begin
      syncref_q <= wr_data & MASK_SYNC_REF;
    end
  end

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  // bits alone decide, no mode term
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_frame_clock_driver_off  <= 1'b0;
      o_bit_clock_driver_off    <= 1'b0;
      o_chan_a_lane1_driver_off <= 1'b0;
      o_chan_a_lane0_driver_off <= 1'b0;
      o_chan_b_lane1_driver_off <= 1'b0;
      o_chan_b_lane0_driver_off <= 1'b0;
    end
    else
    begin
      o_frame_clock_driver_off  <= obuf_q[BIT_FRAME_CLOCK_DRIVER_OFF];
      o_bit_clock_driver_off    <= obuf_q[BIT_BIT_CLOCK_DRIVER_OFF];
      o_chan_a_lane1_driver_off <= obuf_q[BIT_CHAN_A_LANE1_DRIVER_OFF];
      o_chan_a_lane0_driver_off <= obuf_q[BIT_CHAN_A_LANE0_DRIVER_OFF];
      o_chan_b_lane1_driver_off <= obuf_q[BIT_CHAN_B_LANE1_DRIVER_OFF];
      o_chan_b_lane0_driver_off <= obuf_q[BIT_CHAN_B_LANE0_DRIVER_OFF];
    end
  end

  // ****************************************************************
  // Global standby and sync
  // ****************************************************************
  logic standby;
  logic pin_q;
  logic serial_trig_q;

  // shared pin means standby only with pin-sync off
  assign standby = i_global_standby | (i_shared_sync_standby_pin & ~syncref_q[BIT_PIN_SYNC_ENABLE]);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_standby_active          <= 1'b0;
      o_sample_clock_buffer_off <= 1'b0;
      o_reference_amplifier_off <= 1'b0;
      o_bandgap_off             <= 1'b0;
      o_long_wakeup             <= 1'b0;
    end
    else
    begin
      o_standby_active          <= standby;
      o_sample_clock_buffer_off <= (standby & ~gmask_q[BIT_KEEP_SAMPLE_CLOCK_BUFFER])
                                   | (syncref_q[BIT_REFERENCE_CONTROL_SOURCE]
                                      & syncref_q[BIT_SINGLE_ENDED_CLOCK_EN]);
      o_reference_amplifier_off <= standby & ~gmask_q[BIT_KEEP_REFERENCE_AMPLIFIER];
      o_bandgap_off             <= standby & gmask_q[BIT_BANDGAP_OFF_IN_STANDBY];
      o_long_wakeup             <= gmask_q[BIT_BANDGAP_OFF_IN_STANDBY];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pin_q         <= 1'b0;
      serial_trig_q <= 1'b0;
      o_sync_pulse  <= 1'b0;
    end
    else
    begin
      pin_q         <= i_shared_sync_standby_pin;
      serial_trig_q <= syncref_q[BIT_SERIAL_SYNC_TRIGGER];
      // pin rise issues sync when enabled
      o_sync_pulse  <= (i_shared_sync_standby_pin & ~pin_q & syncref_q[BIT_PIN_SYNC_ENABLE])
                       | ((syncref_q[BIT_SERIAL_SYNC_TRIGGER] ^ serial_trig_q)
                          & syncref_q[BIT_SERIAL_SYNC_ENABLE]);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_reference_control_source  <= 1'b0;
      o_reference_select          <= 2'h0;
      o_single_ended_clock_enable <= 1'b0;
    end
    else
    begin
      o_reference_control_source  <= syncref_q[BIT_REFERENCE_CONTROL_SOURCE];
      o_reference_select          <= syncref_q[BIT_REFERENCE_SELECT_HI:BIT_REFERENCE_SELECT_LO];
      o_single_ended_clock_enable <= syncref_q[BIT_SINGLE_ENDED_CLOCK_EN];
    end
  end

endmodule

// [logic/powerdown_mask_pkg.sv]
//
// Purpose : Constants for the power-down and mask register bank
// Assumes : Serial port pins are synchronous to i_sys_clk
// Notes   : Serial frame is 16 bits, MSB first
//
package powerdown_mask_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [6:0] OFS_OUTPUT_BUFFER_POWERDOWN     = 7'h09;
  localparam logic [6:0] OFS_GLOBAL_POWERDOWN_MASK       = 7'h0D;
  localparam logic [6:0] OFS_SYNC_REFERENCE_CLOCK_SELECT = 7'h0E;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_FRAME_CLOCK_DRIVER_OFF   = 5;
  localparam int BIT_BIT_CLOCK_DRIVER_OFF     = 4;
  localparam int BIT_CHAN_A_LANE1_DRIVER_OFF  = 3;
  localparam int BIT_CHAN_A_LANE0_DRIVER_OFF  = 2;
  localparam int BIT_CHAN_B_LANE1_DRIVER_OFF  = 1;
  localparam int BIT_CHAN_B_LANE0_DRIVER_OFF  = 0;

  localparam int BIT_KEEP_SAMPLE_CLOCK_BUFFER = 3;
  localparam int BIT_KEEP_REFERENCE_AMPLIFIER = 2;
  localparam int BIT_BANDGAP_OFF_IN_STANDBY   = 1;

  localparam int BIT_PIN_SYNC_ENABLE          = 7;
  localparam int BIT_SERIAL_SYNC_TRIGGER      = 6;
  localparam int BIT_SERIAL_SYNC_ENABLE       = 5;
  localparam int BIT_REFERENCE_CONTROL_SOURCE = 3;
  localparam int BIT_REFERENCE_SELECT_HI      = 2;
  localparam int BIT_REFERENCE_SELECT_LO      = 1;
  localparam int BIT_SINGLE_ENDED_CLOCK_EN    = 0;

  // ****************************************************************
  // Writable masks and reset values
  // ****************************************************************
  localparam logic [7:0] MASK_OUTPUT_BUFFER = 8'h3F;
  localparam logic [7:0] MASK_GLOBAL_MASK   = 8'h0E;
  localparam logic [7:0] MASK_SYNC_REF      = 8'hEF;
  localparam logic [7:0] RST_REGISTER       = 8'h00;

  // ****************************************************************
  // Serial frame
  // ****************************************************************
  localparam logic [3:0] CNT_HEADER_LAST = 4'h7;
  localparam logic [3:0] CNT_FRAME_LAST  = 4'hF;

  typedef enum logic [1:0] {PH_IDLE, PH_HEADER, PH_DATA, PH_DONE} spi_phase_t;

endpackage

// [bench/powerdown_mask_registers_sva.sv]
// Purpose : Port assertions for the power-down register bank
// Assumes : One clock, asynchronous active-low reset
// Notes   : Bound to the design by the line after endmodule
`timescale 1ns/1ps
module pdm_chk (
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic       i_sen_n,
  input wire logic       i_global_standby,
  input wire logic       i_shared_sync_standby_pin,
  input wire logic       o_sdout_oe_n,
  input wire logic       o_frame_clock_driver_off,
  input wire logic       o_bit_clock_driver_off,
  input wire logic       o_chan_a_lane1_driver_off,
  input wire logic       o_chan_a_lane0_driver_off,
  input wire logic       o_chan_b_lane1_driver_off,
  input wire logic       o_chan_b_lane0_driver_off,
  input wire logic       o_standby_active,
  input wire logic       o_reference_amplifier_off,
  input wire logic       o_bandgap_off,
  input wire logic       o_long_wakeup,
  input wire logic       o_sync_pulse,
  input wire logic [1:0] o_reference_select
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  logic [5:0] drv;
  assign drv = {o_frame_clock_driver_off, o_bit_clock_driver_off, o_chan_a_lane1_driver_off,
                o_chan_a_lane0_driver_off, o_chan_b_lane1_driver_off, o_chan_b_lane0_driver_off};
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence idle_s;
    i_sen_n [*3];
  endsequence
  sequence calm_s;
    (!i_global_standby && !i_shared_sync_standby_pin) [*3];
  endsequence
  drv_hold_a : assert property (idle_s |-> $stable(drv))
    else $error("driver bits moved with no frame");
  sel_hold_a : assert property (idle_s |-> $stable(o_reference_select))
    else $error("reference select moved with no frame");
  stby_on_a : assert property (i_global_standby [*3] |-> o_standby_active)
    else $error("standby input ignored");
  stby_off_a : assert property (calm_s |-> !o_standby_active)
    else $error("standby without a cause");
  amp_calm_a : assert property (calm_s |-> !o_reference_amplifier_off)
    else $error("amplifier off outside standby");
  bg_calm_a : assert property (calm_s |-> !o_bandgap_off)
    else $error("bandgap off outside standby");
  bg_flag_a : assert property (o_bandgap_off |-> o_long_wakeup)
    else $error("bandgap off without long wake-up flag");
  sync_once_a : assert property (o_sync_pulse |=> !o_sync_pulse)
    else $error("sync pulse longer than one cycle");
  rst_zero_a : assert property ($rose(i_rstn) |-> drv == 6'h00)
    else $error("driver bits not zero after reset");
  oe_idle_a : assert property (idle_s |-> o_sdout_oe_n)
    else $error("read driver enabled with no frame");
endmodule
bind powerdown_mask_registers pdm_chk u_chk (.*);

// [bench/spi_host_model.sv]
// Purpose : Serial host that writes and reads the bank
// Assumes : Pins change on falling system clock edges
// Notes   : Serial clock is low for six system clocks and high for three
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_sdout,
  output logic      o_sen_n,
  output logic      o_sclk,
  output logic      o_sdio
);
  initial
  begin
    o_sen_n = 1'b1;
    o_sclk  = 1'b0;
    o_sdio  = 1'b0;
  end
  // ****************************************************************
  // One 16-bit frame, MSB first
  // ****************************************************************
  task automatic frame(input logic [15:0] w, output logic [7:0] r);
    @(negedge i_sys_clk);
    o_sen_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      repeat (3) @(negedge i_sys_clk);
      o_sdio = w[i];
      repeat (3) @(negedge i_sys_clk);
      if (i < 8)
        r[i] = i_sdout;
      o_sclk = 1'b1;
      repeat (3) @(negedge i_sys_clk);
      o_sclk = 1'b0;
    end
    repeat (3) @(negedge i_sys_clk);
    o_sen_n = 1'b1;
    // Released data line shows no stale value
    o_sdio = ~o_sdio;
    repeat (3) @(negedge i_sys_clk);
  endtask
endmodule

// [bench/testbench.sv]
// Purpose : Register and power-down checks through the serial port
// Assumes : Host model drives the serial pins
// Notes   : Watchdog ends a hung run
`timescale 1ns/1ps
module testbench;
  import powerdown_mask_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_global_standby = 1'b0;
  logic i_shared_sync_standby_pin = 1'b0;
  logic i_sen_n, i_sclk, i_sdio, o_sdout, o_sdout_oe_n, o_standby_active, o_sync_pulse;
  logic o_frame_clock_driver_off, o_bit_clock_driver_off, o_chan_a_lane1_driver_off;
  logic o_chan_a_lane0_driver_off, o_chan_b_lane1_driver_off, o_chan_b_lane0_driver_off;
  logic o_sample_clock_buffer_off, o_reference_amplifier_off, o_bandgap_off, o_long_wakeup;
  logic o_reference_control_source, o_single_ended_clock_enable;
  logic [1:0] o_reference_select;
  int errors = 0;
  int compares = 0;
  int pulses = 0;
  int p0 = 0;
  logic [7:0] r;
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk)
    if (o_sync_pulse === 1'b1)
      pulses++;
  powerdown_mask_registers dut (.*);
  spi_host_model u_host (.i_sys_clk(i_sys_clk), .i_sdout(o_sdout), .o_sen_n(i_sen_n),
                         .o_sclk(i_sclk), .o_sdio(i_sdio));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.frame({1'b0, a, d}, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    u_host.frame({1'b1, a, 8'h00}, d);
  endtask
  function automatic logic [7:0] drv();
    return {2'b00, o_frame_clock_driver_off, o_bit_clock_driver_off, o_chan_a_lane1_driver_off,
            o_chan_a_lane0_driver_off, o_chan_b_lane1_driver_off, o_chan_b_lane0_driver_off};
  endfunction
  function automatic logic [7:0] ana();
    return {4'h0, o_sample_clock_buffer_off, o_reference_amplifier_off, o_bandgap_off, o_long_wakeup};
  endfunction
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (16) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    rd(OFS_OUTPUT_BUFFER_POWERDOWN, r);
    chk("obuf reset", r, 8'h00);
    rd(OFS_GLOBAL_POWERDOWN_MASK, r);
    chk("mask reset", r, 8'h00);
    rd(OFS_SYNC_REFERENCE_CLOCK_SELECT, r);
    chk("sync reset", r, 8'h00);
    $display("test reset done");
    for (int b = 0; b < 6; b++)
    begin
      wr(OFS_OUTPUT_BUFFER_POWERDOWN, 8'h01 << b);
      chk("drivers", drv(), 8'h01 << b);
    end
    wr(OFS_OUTPUT_BUFFER_POWERDOWN, 8'hFF);
    rd(OFS_OUTPUT_BUFFER_POWERDOWN, r);
    chk("obuf read", r, MASK_OUTPUT_BUFFER);
    $display("test drivers done");
    i_global_standby = 1'b1;
    wr(OFS_GLOBAL_POWERDOWN_MASK, 8'h00);
    chk("standby mask 0", ana(), 8'h0C);
    wr(OFS_GLOBAL_POWERDOWN_MASK, 8'hFF);
    chk("standby mask 1", ana(), 8'h03);
    rd(OFS_GLOBAL_POWERDOWN_MASK, r);
    chk("mask read", r, MASK_GLOBAL_MASK);
    i_global_standby = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    chk("awake", ana(), 8'h01);
    $display("test mask done");
    wr(OFS_SYNC_REFERENCE_CLOCK_SELECT, 8'hFF);
    rd(OFS_SYNC_REFERENCE_CLOCK_SELECT, r);
    chk("sync read", r, MASK_SYNC_REF);
    chk("fields", {4'h0, o_reference_control_source, o_reference_select, o_single_ended_clock_enable},
        8'h0F);
    p0 = pulses;
    i_shared_sync_standby_pin = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk("pin sync", {o_standby_active, 7'(pulses - p0)}, 8'h01);
    i_shared_sync_standby_pin = 1'b0;
    wr(OFS_SYNC_REFERENCE_CLOCK_SELECT, 8'h00);
    i_shared_sync_standby_pin = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk("pin standby", {7'h00, o_standby_active}, 8'h01);
    i_shared_sync_standby_pin = 1'b0;
    $display("test sync done");
    wr(7'h20, 8'hFF);
    rd(7'h20, r);
    chk("unmapped", r, 8'h00);
    chk("drivers kept", drv(), 8'h3F);
    $display("test unmapped done");
    wrap_up();
  end
  initial
  begin
    #150000;
    errors++;
    wrap_up();
  end
endmodule
